// ==== sdcc_pkg.sv ====
// Package with register map, field layout and timing constants of the SDRAM controller.
package sdcc_pkg;
    localparam logic [7:0] ADDR_TIMING = 8'h00;
    localparam logic [7:0] ADDR_SREXIT = 8'h04;
    localparam logic [7:0] ADDR_REFRESH = 8'h08;
    localparam logic [7:0] ADDR_CONFIG = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam int RFC_HI = 31;
    localparam int RFC_LO = 27;
    localparam int RP_HI = 26;
    localparam int RP_LO = 24;
    localparam int RCD_HI = 22;
    localparam int RCD_LO = 20;
    localparam int WR_HI = 18;
    localparam int WR_LO = 16;
    localparam int RAS_HI = 15;
    localparam int RAS_LO = 12;
    localparam int RC_HI = 11;
    localparam int RC_LO = 8;
    localparam int RRD_HI = 6;
    localparam int RRD_LO = 4;
    localparam int SR_BIT = 31;
    localparam int NM_BIT = 14;
    localparam int CL_HI = 11;
    localparam int CL_LO = 9;
    localparam int UNLOCK_BIT = 8;
    localparam int BANK_HI = 6;
    localparam int BANK_LO = 4;
    localparam int PAGE_HI = 2;
    localparam int PAGE_LO = 0;
    localparam logic [31:0] TIMING_MASK = 32'hFF77F770;
    localparam logic [31:0] CONFIG_MASK = 32'h80004E77;
    localparam logic [31:0] TIMING_RST = 32'hFF77F770;
    localparam logic [31:0] CONFIG_RST = 32'h00000620;
    localparam logic [4:0] SREXIT_RST = 5'h1F;
    localparam logic [12:0] REFRESH_RST = 13'h061A;
    localparam logic [3:0] INIT_REFRESHES = 4'h8;
    typedef enum logic [2:0] {
        SDCC_INIT_PRE, SDCC_INIT_REF, SDCC_INIT_MRS, SDCC_IDLE,
        SDCC_REFRESH, SDCC_SELF, SDCC_EXIT
    } sdcc_state_t;
endpackage : sdcc_pkg

// ==== sdcc_wait.sv ====
// Down counter that times a minimum interval of a field value plus one cycles.
`timescale 1ns/100ps
module sdcc_wait (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [12:0] value,
    output logic busy
);
    logic [12:0] count;
    logic [12:0] next_count;

    // RQ4 plus one wait
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = value;
        end else if (count != 13'h0000) begin
            next_count = count - 13'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= 13'h0000;
        end else begin
            count <= next_count;
        end
    end

    // Busy comes from the count alone, so the load decision never loops back on itself.
    assign busy = count != 13'h0000;
endmodule : sdcc_wait

// ==== sdcc_ctrl.sv ====
// Register file, sequencer and refresh timer of the SDRAM controller.
// Operation
// RQ1: Self-refresh request bit 31 enters self-refresh; clearing it exits.
// RQ2: Top-byte-only config write changes self-refresh without starting initialization.
// RQ3: Software enters self-refresh before changing interface clock, then clears it.
// RQ4: Each timing field waits at least value plus one cycles; only RP, RFC and RRD set a wait, RCD, WR, RAS and RC are stored but unused.
// RQ5: Timing register holds seven fields at their fixed bit positions; TIMING_MASK clears bit 11, so RC keeps only bits 10-8.
// RQ6: After clock enable rises, wait exit time plus one before commands.
// RQ7: Auto-refresh request issued every refresh interval cycles.
// RQ8: Software writes timing, exit, refresh, then config; accesses then accepted.
// RQ9: Narrow bus select at bit 14 chooses a 16-bit data bus.
// RQ10: Cas latency select in bits 11-9 sets read latency.
// RQ11: Latency field updates only when the unlock bit is written one.
// RQ12: Bank count field bits 6-4 selects internal bank count.
// RQ13: Row length field bits 2-0 selects page size.
// RQ14: Lower-byte config write restarts initialization with new settings.
// RQ15: Refresh suppressed during self-refresh; resumes after exit delay.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module sdcc_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic sdram_cke,
    output logic [2:0] sdram_cmd,
    output logic sdram_ready,
    output logic narrow_bus,
    output logic [2:0] cas_latency,
    output logic [2:0] bank_count,
    output logic [2:0] page_size
);
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_PRE = 3'h1;
    localparam logic [2:0] CMD_REF = 3'h2;
    localparam logic [2:0] CMD_MRS = 3'h3;
    localparam logic [2:0] CMD_SRE = 3'h4;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    logic [31:0] timing;
    logic [31:0] config_reg;
    logic [4:0] srexit;
    logic [12:0] refresh;
    logic ack;
    logic [31:0] rdata;
    logic init_req;
    logic [31:0] next_timing;
    logic [31:0] next_config;
    logic [4:0] next_srexit;
    logic [12:0] next_refresh;
    logic next_ack;
    logic [31:0] next_rdata;
    logic next_init_req;
    logic wr;
    logic [31:0] cfg_w;
    sdcc_pkg::sdcc_state_t state;
    logic ref_due;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack;

    always_comb begin
        next_timing = timing;
        next_config = config_reg;
        next_srexit = srexit;
        next_refresh = refresh;
        next_init_req = 1'b0;
        next_ack = wb_cyc_i && wb_stb_i && !ack;
        next_rdata = 32'h00000000;
        cfg_w = merge(config_reg, wb_dat_i, wb_sel_i) & sdcc_pkg::CONFIG_MASK;
        if (wr) begin
            if (wb_adr_i == sdcc_pkg::ADDR_TIMING) begin
                // RQ5 timing fields
                next_timing = merge(timing, wb_dat_i, wb_sel_i) & sdcc_pkg::TIMING_MASK;
            end else if (wb_adr_i == sdcc_pkg::ADDR_SREXIT) begin
                next_srexit = sel_merge_low5(srexit, wb_dat_i, wb_sel_i[0]);
            end else if (wb_adr_i == sdcc_pkg::ADDR_REFRESH) begin
                next_refresh = {wb_sel_i[1] ? wb_dat_i[12:8] : refresh[12:8],
                                wb_sel_i[0] ? wb_dat_i[7:0] : refresh[7:0]};
            end else if (wb_adr_i == sdcc_pkg::ADDR_CONFIG) begin
                // RQ11 latency unlock
                if (!(wb_sel_i[1] && wb_dat_i[sdcc_pkg::UNLOCK_BIT])) begin
                    cfg_w[sdcc_pkg::CL_HI:sdcc_pkg::CL_LO] =
                        config_reg[sdcc_pkg::CL_HI:sdcc_pkg::CL_LO];
                end
                cfg_w[sdcc_pkg::UNLOCK_BIT] = 1'b0;
                next_config = cfg_w;
                // RQ2 RQ14 init on low bytes
                next_init_req = |wb_sel_i[2:0];
            end
        end
        if (wb_adr_i == sdcc_pkg::ADDR_TIMING) begin
            next_rdata = timing;
        end else if (wb_adr_i == sdcc_pkg::ADDR_SREXIT) begin
            next_rdata = {27'h0000000, srexit};
        end else if (wb_adr_i == sdcc_pkg::ADDR_REFRESH) begin
            next_rdata = {19'h00000, refresh};
        end else if (wb_adr_i == sdcc_pkg::ADDR_CONFIG) begin
            next_rdata = config_reg;
        end else if (wb_adr_i == sdcc_pkg::ADDR_STATUS) begin
            next_rdata = {29'h00000000, status_bits()};
        end
    end

    function automatic logic [4:0] sel_merge_low5(input logic [4:0] old, input logic [31:0] din,
                                                  input logic sel0);
        return sel0 ? din[4:0] : old;
    endfunction : sel_merge_low5

    sdcc_pkg::sdcc_state_t next_state;
    logic [12:0] ref_count;
    logic [12:0] next_ref_count;
    logic next_ref_due;
    logic [3:0] init_left;
    logic [3:0] next_init_left;
    logic next_cke;
    logic [2:0] next_cmd;
    logic next_ready;
    logic wait_load;
    logic [12:0] wait_value;
    logic wait_busy;
    logic ref_hit;

    function automatic logic [2:0] status_bits();
        return {state == sdcc_pkg::SDCC_SELF, ref_due, state == sdcc_pkg::SDCC_IDLE};
    endfunction : status_bits

    sdcc_wait u_wait (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(wait_load),
        .value(wait_value),
        .busy(wait_busy)
    );

    always_comb begin
        next_state = state;
        next_ref_count = ref_count;
        next_ref_due = ref_due;
        next_init_left = init_left;
        next_cke = sdram_cke;
        next_cmd = CMD_NOP;
        next_ready = 1'b0;
        wait_load = 1'b0;
        wait_value = 13'h0000;
        ref_hit = 1'b0;
        // RQ7 refresh interval
        if (ref_count + 13'h0001 >= refresh) begin
            next_ref_count = 13'h0000;
            // RQ15 suppress in self-refresh
            if (state != sdcc_pkg::SDCC_SELF && state != sdcc_pkg::SDCC_EXIT) begin
                next_ref_due = 1'b1;
                ref_hit = 1'b1;
            end
        end else begin
            next_ref_count = ref_count + 13'h0001;
        end
        if (!wait_busy) begin
            case (state)
                sdcc_pkg::SDCC_INIT_PRE: begin
                    next_cke = 1'b1;
                    next_cmd = CMD_PRE;
                    wait_load = 1'b1;
                    wait_value = {10'h000, timing[sdcc_pkg::RP_HI:sdcc_pkg::RP_LO]};
                    next_init_left = sdcc_pkg::INIT_REFRESHES;
                    next_state = sdcc_pkg::SDCC_INIT_REF;
                end
                sdcc_pkg::SDCC_INIT_REF: begin
                    next_cmd = CMD_REF;
                    wait_load = 1'b1;
                    wait_value = {8'h00, timing[sdcc_pkg::RFC_HI:sdcc_pkg::RFC_LO]};
                    next_init_left = init_left - 4'h1;
                    if (init_left == 4'h1) begin
                        next_state = sdcc_pkg::SDCC_INIT_MRS;
                    end
                end
                sdcc_pkg::SDCC_INIT_MRS: begin
                    next_cmd = CMD_MRS;
                    wait_load = 1'b1;
                    wait_value = {10'h000, timing[sdcc_pkg::RRD_HI:sdcc_pkg::RRD_LO]};
                    next_ref_due = 1'b0;
                    next_state = sdcc_pkg::SDCC_IDLE;
                end
                sdcc_pkg::SDCC_IDLE: begin
                    // RQ8 ready after config
                    next_ready = 1'b1;
                    if (init_req) begin
                        next_ready = 1'b0;
                        next_state = sdcc_pkg::SDCC_INIT_PRE;
                    end else if (config_reg[sdcc_pkg::SR_BIT]) begin
                        // RQ1 enter self-refresh
                        next_ready = 1'b0;
                        next_cmd = CMD_SRE;
                        next_cke = 1'b0;
                        next_ref_due = 1'b0;
                        next_state = sdcc_pkg::SDCC_SELF;
                    end else if (ref_due) begin
                        next_ready = 1'b0;
                        next_state = sdcc_pkg::SDCC_REFRESH;
                    end
                end
                sdcc_pkg::SDCC_REFRESH: begin
                    // RQ4 refresh cycle time
                    next_cmd = CMD_REF;
                    next_ref_due = ref_hit;
                    wait_load = 1'b1;
                    wait_value = {8'h00, timing[sdcc_pkg::RFC_HI:sdcc_pkg::RFC_LO]};
                    next_state = sdcc_pkg::SDCC_IDLE;
                end
                sdcc_pkg::SDCC_SELF: begin
                    next_ref_due = 1'b0;
                    if (!config_reg[sdcc_pkg::SR_BIT]) begin
                        // RQ1 RQ6 exit and wait
                        next_cke = 1'b1;
                        wait_load = 1'b1;
                        wait_value = {8'h00, srexit};
                        next_state = sdcc_pkg::SDCC_EXIT;
                    end
                end
                sdcc_pkg::SDCC_EXIT: begin
                    next_ref_count = 13'h0000;
                    next_state = sdcc_pkg::SDCC_IDLE;
                end
                default: begin
                    next_state = sdcc_pkg::SDCC_INIT_PRE;
                end
            endcase
        end
    end

    // A pending restart is held until the sequencer can take it.
    logic init_pending;
    logic next_init_pending;
    always_comb begin
        next_init_pending = init_pending;
        if (next_init_req) begin
            next_init_pending = 1'b1;
        end else if (!wait_busy && state == sdcc_pkg::SDCC_IDLE) begin
            next_init_pending = 1'b0;
        end
    end
    assign init_req = init_pending;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timing <= sdcc_pkg::TIMING_RST;
            config_reg <= sdcc_pkg::CONFIG_RST;
            srexit <= sdcc_pkg::SREXIT_RST;
            refresh <= sdcc_pkg::REFRESH_RST;
            ack <= 1'b0;
            rdata <= 32'h00000000;
            init_pending <= 1'b0;
            state <= sdcc_pkg::SDCC_INIT_PRE;
            ref_count <= 13'h0000;
            ref_due <= 1'b0;
            init_left <= 4'h0;
            sdram_cke <= 1'b0;
            sdram_cmd <= 3'h0;
            sdram_ready <= 1'b0;
            narrow_bus <= 1'b0;
            cas_latency <= 3'h3;
            bank_count <= 3'h2;
            page_size <= 3'h0;
        end else begin
            timing <= next_timing;
            config_reg <= next_config;
            srexit <= next_srexit;
            refresh <= next_refresh;
            ack <= next_ack;
            rdata <= next_rdata;
            init_pending <= next_init_pending;
            state <= next_state;
            ref_count <= next_ref_count;
            ref_due <= next_ref_due;
            init_left <= next_init_left;
            sdram_cke <= next_cke;
            sdram_cmd <= next_cmd;
            sdram_ready <= next_ready;
            // RQ9 RQ10 RQ12 RQ13 fields
            narrow_bus <= config_reg[sdcc_pkg::NM_BIT];
            cas_latency <= config_reg[sdcc_pkg::CL_HI:sdcc_pkg::CL_LO];
            bank_count <= config_reg[sdcc_pkg::BANK_HI:sdcc_pkg::BANK_LO];
            page_size <= config_reg[sdcc_pkg::PAGE_HI:sdcc_pkg::PAGE_LO];
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    // RQ11 locked latency check
    a_cl_lock_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (wr && wb_adr_i == sdcc_pkg::ADDR_CONFIG && !(wb_sel_i[1] && wb_dat_i[8]))
        |=> $stable(config_reg[11:9])) else $error("Latency changed without unlock.");
    // RQ2 top byte no init
    a_top_byte_noinit: assert property (@(posedge ref_clk) disable iff (rst)
        (wr && wb_adr_i == sdcc_pkg::ADDR_CONFIG && wb_sel_i == 4'h8 && !init_pending)
        |=> !init_pending) else $error("Top byte write started initialization.");
    // RQ14 low byte init
    a_low_byte_init: assert property (@(posedge ref_clk) disable iff (rst)
        (wr && wb_adr_i == sdcc_pkg::ADDR_CONFIG && wb_sel_i[0]) |=> init_pending)
        else $error("Low byte write did not request initialization.");
    // RQ1 self-refresh entry
    a_sr_entry: assert property (@(posedge ref_clk) disable iff (rst)
        (state == sdcc_pkg::SDCC_IDLE && !wait_busy && !init_pending && config_reg[31])
        |=> (state == sdcc_pkg::SDCC_SELF && !sdram_cke && sdram_cmd == 3'h4))
        else $error("Self-refresh not entered.");
    // RQ6 exit delay
    a_exit_wait: assert property (@(posedge ref_clk) disable iff (rst)
        (state == sdcc_pkg::SDCC_SELF && $past(state) == sdcc_pkg::SDCC_SELF
         && !config_reg[31] && !wait_busy)
        |=> sdram_cke ##1 (sdram_cmd == 3'h0)) else $error("Command too soon after exit.");
    // RQ15 no refresh in self-refresh
    a_no_ref_self: assert property (@(posedge ref_clk) disable iff (rst)
        (state == sdcc_pkg::SDCC_SELF) |-> !ref_due) else $error("Refresh due in self-refresh.");
    // RQ7 refresh flagged
    a_ref_flag: assert property (@(posedge ref_clk) disable iff (rst)
        (ref_count + 13'h0001 == refresh && refresh != 13'h0000
         && state == sdcc_pkg::SDCC_IDLE && !config_reg[31])
        |=> ref_due) else $error("Refresh interval missed.");
    // RQ4 refresh spacing
    a_ref_spacing: assert property (@(posedge ref_clk) disable iff (rst)
        (sdram_cmd == 3'h2 && timing[31:27] != 5'h00) |=> (sdram_cmd == 3'h0))
        else $error("Command inside refresh cycle time.");
endmodule : sdcc_ctrl

// ==== sdcc_sdram_model.sv ====
// Behavioural SDRAM device model that counts commands and measures their spacing.
`timescale 1ns/100ps
module sdcc_sdram_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sdram_cke,
    input wire logic [2:0] sdram_cmd,
    output int pre_count,
    output int ref_count,
    output int min_pre_gap,
    output int min_ref_gap,
    output int last_ref_gap,
    output int exit_gap,
    output logic in_self
);
    int gap;
    int since_cke;
    int since_ref;
    logic [2:0] prev_cmd;
    logic cke_q;
    logic exit_wait;
    always @(posedge ref_clk) begin
        cke_q <= sdram_cke;
        if (rst) begin
            gap <= 1000;
            since_cke <= 0;
            since_ref <= 0;
            prev_cmd <= 3'h0;
            in_self <= 1'b0;
            exit_wait <= 1'b0;
            pre_count <= 0;
            ref_count <= 0;
            min_pre_gap <= 1000;
            min_ref_gap <= 1000;
            last_ref_gap <= 0;
            exit_gap <= 0;
        end else begin
            gap <= gap + 1;
            since_cke <= since_cke + 1;
            since_ref <= since_ref + 1;
            if (sdram_cke && !cke_q && in_self) begin
                in_self <= 1'b0;
                exit_wait <= 1'b1;
                since_cke <= 1;
            end
            if (sdram_cmd != 3'h0) begin
                gap <= 1;
                prev_cmd <= sdram_cmd;
                if (prev_cmd == 3'h1 && gap < min_pre_gap) min_pre_gap <= gap;
                if (prev_cmd == 3'h2 && gap < min_ref_gap) min_ref_gap <= gap;
                if (exit_wait) begin
                    exit_gap <= since_cke;
                    exit_wait <= 1'b0;
                end
                if (sdram_cmd == 3'h1) pre_count <= pre_count + 1;
                if (sdram_cmd == 3'h2) begin
                    ref_count <= ref_count + 1;
                    last_ref_gap <= since_ref;
                    since_ref <= 1;
                end
                if (sdram_cmd == 3'h4) in_self <= 1'b1;
            end
        end
    end
endmodule : sdcc_sdram_model

// ==== test_sdram_controller_config.sv ====
// Bench for the SDRAM controller registers and command sequencer.
`timescale 1ns/100ps
module test_sdram_controller_config;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic [31:0] rdata;
    logic wb_ack_o, sdram_cke, sdram_ready, narrow_bus, in_self;
    logic [2:0] sdram_cmd, cas_latency, bank_count, page_size;
    int pre_count, ref_count, min_pre_gap, min_ref_gap, last_ref_gap, exit_gap;
    int fail_count = 0;
    int comparisons = 0;
    always #2 ref_clk = ~ref_clk;
    sdcc_ctrl sdcc_ctrl_inst (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sdram_cke, .sdram_cmd, .sdram_ready,
        .narrow_bus, .cas_latency, .bank_count, .page_size);
    sdcc_sdram_model sdcc_sdram_model_inst (.ref_clk, .rst, .sdram_cke, .sdram_cmd,
        .pre_count, .ref_count, .min_pre_gap, .min_ref_gap, .last_ref_gap, .exit_gap,
        .in_self);
    task automatic end_sim;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
            input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            check(32'h0, 32'h1, "bus answer timeout");
            end_sim();
        end
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] adr);
        wb(1'b0, adr, 4'hF, 32'h00000000);
    endtask : rd
    // A bounded wait on ready or clock enable; a hang ends the run.
    task automatic wait_for(input logic use_cke, input logic lvl);
        int n;
        n = 0;
        while ((use_cke ? sdram_cke : sdram_ready) !== lvl && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 3000) begin
            check(32'h0, 32'h1, "level wait timeout");
            end_sim();
        end
    endtask : wait_for
    task automatic cfg(input logic [31:0] dat);
        wb(1'b1, sdcc_pkg::ADDR_CONFIG, 4'hF, dat);
        wait_for(1'b0, 1'b0);
        wait_for(1'b0, 1'b1);
    endtask : cfg
    task automatic t_reset;
        check({29'h0, cas_latency}, 32'h3, "reset latency");
        check({29'h0, bank_count}, 32'h2, "reset banks");
        check({29'h0, page_size}, 32'h0, "reset page");
        rd(sdcc_pkg::ADDR_TIMING);
        check(rdata, sdcc_pkg::TIMING_RST, "timing reset");
        rd(sdcc_pkg::ADDR_SREXIT);
        check(rdata, {27'h0, sdcc_pkg::SREXIT_RST}, "exit reset");
        rd(sdcc_pkg::ADDR_REFRESH);
        check(rdata, {19'h0, sdcc_pkg::REFRESH_RST}, "refresh reset");
        rd(sdcc_pkg::ADDR_CONFIG);
        check(rdata, sdcc_pkg::CONFIG_RST, "config reset");
        wb(1'b1, 8'h40, 4'hF, 32'hFFFFFFFF);
        rd(8'h40);
        check(rdata, 32'h0, "unmapped read");
    endtask : t_reset
    task automatic t_program;
        int pc;
        wb(1'b1, sdcc_pkg::ADDR_TIMING, 4'hF, 32'hFFFFFFFF);
        rd(sdcc_pkg::ADDR_TIMING);
        check(rdata, sdcc_pkg::TIMING_MASK, "timing fields");
        wb(1'b1, sdcc_pkg::ADDR_TIMING, 4'hF, 32'h4B114610);
        wb(1'b1, sdcc_pkg::ADDR_SREXIT, 4'hF, 32'h00000006);
        wb(1'b1, sdcc_pkg::ADDR_REFRESH, 4'hF, 32'h00000028);
        pc = pre_count;
        cfg(32'h00004720);
        check({31'h0, pre_count > pc}, 32'h1, "init after config");
        check({31'h0, narrow_bus}, 32'h1, "narrow bus");
        check({29'h0, cas_latency}, 32'h3, "latency three");
        check({29'h0, bank_count}, 32'h2, "four banks");
        check({29'h0, page_size}, 32'h0, "page size");
        rd(sdcc_pkg::ADDR_CONFIG);
        check(rdata, 32'h00004620, "config readback");
        // Precharge time is 3 and refresh cycle time 9 in the value above.
        check({31'h0, min_pre_gap >= 4}, 32'h1, "precharge spacing");
        check({31'h0, min_ref_gap >= 10}, 32'h1, "refresh spacing");
    endtask : t_program
    task automatic t_latency;
        cfg(32'h00000420);
        check({31'h0, narrow_bus}, 32'h0, "wide bus");
        check({29'h0, cas_latency}, 32'h3, "locked latency");
        cfg(32'h00004520);
        check({29'h0, cas_latency}, 32'h2, "unlocked latency");
        cfg(32'h00004720);
    endtask : t_latency
    task automatic t_refresh;
        int rc;
        int n;
        rc = ref_count;
        n = 0;
        while (ref_count < rc + 2 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 1000) begin
            check(32'h0, 32'h1, "refresh wait timeout");
            end_sim();
        end
        check(last_ref_gap, 32'd40, "refresh period");
    endtask : t_refresh
    task automatic t_self;
        int pc;
        int rc;
        pc = pre_count;
        wb(1'b1, sdcc_pkg::ADDR_CONFIG, 4'h8, 32'h80000000);
        wait_for(1'b1, 1'b0);
        repeat (5) @(posedge ref_clk);
        check({31'h0, in_self}, 32'h1, "self entry");
        rc = ref_count;
        repeat (150) @(posedge ref_clk);
        check(ref_count, rc, "no refresh asleep");
        rd(sdcc_pkg::ADDR_CONFIG);
        check(rdata, 32'h80004620, "sleep bit only");
        rd(sdcc_pkg::ADDR_STATUS);
        check(rdata, 32'h00000004, "asleep status");
        wb(1'b1, sdcc_pkg::ADDR_CONFIG, 4'h8, 32'h00000000);
        wait_for(1'b1, 1'b1);
        repeat (100) @(posedge ref_clk);
        check({31'h0, exit_gap >= 7}, 32'h1, "exit delay");
        check({31'h0, ref_count > rc}, 32'h1, "refresh resumes");
        check(pre_count, pc, "no init on byte write");
        check({31'h0, sdram_ready}, 32'h1, "awake and ready");
    endtask : t_self
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        wait_for(1'b0, 1'b1);
        t_program();
        t_latency();
        t_refresh();
        t_self();
        end_sim();
    end
endmodule : test_sdram_controller_config
